// [shared/clock_channel_pkg.sv]
package clock_channel_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_CHANNELS = 28;
   localparam int NUM_GENERATORS = 8;
   localparam int SEL_W = 6;
   localparam int GEN_W = 4;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // Register map: printed offsets are word indices
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CONFIG_INDEX = 12'h002;
   localparam logic [ADDR_W-1:0] STATUS_INDEX = 12'h003;
   localparam logic [ADDR_W-1:0] WORD_BYTES = 12'h004;
   localparam logic [ADDR_W-1:0] CONFIG_ADDR = CONFIG_INDEX * WORD_BYTES;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = STATUS_INDEX * WORD_BYTES;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int LOCK_BIT = 15;
   localparam int ENABLE_BIT = 14;
   localparam int GEN_MSB = 11;
   localparam int GEN_LSB = 8;
   localparam int SEL_MSB = 5;
   localparam int SEL_LSB = 0;
   localparam int SEL_LANE = 0;
   localparam int FIELD_LANE = 1;
   localparam int STAT_REFUSED_BIT = 0;
   localparam int STAT_READY_BIT = 1;
   localparam int STAT_LOCKGEN_LSB = 8;
   localparam int STAT_LOCKGEN_MSB = 15;

   // ----------------------------------------------------------------
   // Channel selector codes
   // ----------------------------------------------------------------
   localparam logic [SEL_W-1:0] CH_FLL_REF = 6'h00;
   localparam logic [SEL_W-1:0] CH_WATCHDOG = 6'h01;
   localparam logic [SEL_W-1:0] CH_RTC = 6'h02;
   localparam logic [SEL_W-1:0] CH_EXT_INT = 6'h03;
   localparam logic [SEL_W-1:0] CH_EVENT_FIRST = 6'h04;
   localparam logic [SEL_W-1:0] CH_SERIAL_SLOW = 6'h0C;
   localparam logic [SEL_W-1:0] CH_SERIAL_CORE_FIRST = 6'h0D;
   localparam logic [SEL_W-1:0] CH_TIMER_FIRST = 6'h13;
   localparam logic [SEL_W-1:0] CH_ANALOG_FIRST = 6'h17;
   localparam logic [SEL_W-1:0] CH_LAST = 6'h1B;

   // ----------------------------------------------------------------
   // Generator codes and reset values
   // ----------------------------------------------------------------
   localparam logic [GEN_W-1:0] GEN_CLEARED = 4'h0;
   localparam logic [GEN_W-1:0] GEN_WATCHDOG_DEFAULT = 4'h2;
   localparam logic [GEN_W-1:0] GEN_LAST = 4'h7;
   localparam logic [1:0] SETTLE_COUNT = 2'h3;

   typedef struct packed {
      logic lock;
      logic enable;
      logic [GEN_W-1:0] generator;
   } chan_cfg_t;

   localparam chan_cfg_t CFG_CLEARED = '{lock: 1'b0, enable: 1'b0, generator: 4'h0};
   localparam chan_cfg_t CFG_WATCHDOG_POWER = '{lock: 1'b0, enable: 1'b0, generator: 4'h2};

   typedef struct packed {
      logic user_reset;
      logic wdt_enable;
      logic wdt_always_on;
   } strap_t;

   localparam int STRAP_W = $bits(strap_t);

endpackage : clock_channel_pkg

// [core/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync
   import clock_channel_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Asynchronous levels
   input wire logic [WIDTH-1:0] async_in,
   // Settled levels
   output logic [WIDTH-1:0] stable_out
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;
   logic [WIDTH-1:0] stable_reg;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // A bit only moves once the last two stages agree, so one metastable sample is absorbed.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         stable_reg <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2_reg[i] == stage3_reg[i]) begin
               stable_reg[i] <= stage3_reg[i];
            end
         end
      end
   end

   assign stable_out = stable_reg;

endmodule : pin_sync

// [core/channel_slot.sv]
`timescale 1ns/100ps
module channel_slot
   import clock_channel_pkg::*;
#(
   parameter logic IS_WATCHDOG = 1'b0,
   parameter logic IS_RTC = 1'b0
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Control
   input wire logic user_reset_in,
   input wire logic strap_load_in,
   input wire logic wdt_enable_in,
   input wire logic wdt_always_on_in,
   input wire logic write_in,
   input wire chan_cfg_t write_cfg_in,
   // Stored configuration
   output chan_cfg_t cfg_out
);

   chan_cfg_t cfg_reg;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_reg <= IS_WATCHDOG ? CFG_WATCHDOG_POWER : CFG_CLEARED;
      end else if (user_reset_in) begin
         if (IS_RTC) begin
            if (!cfg_reg.lock && !cfg_reg.enable) begin
               cfg_reg.generator <= GEN_CLEARED;
               cfg_reg.enable <= 1'b0;
            end
         end else if (!cfg_reg.lock) begin
            if (IS_WATCHDOG) begin
               cfg_reg.generator <= GEN_WATCHDOG_DEFAULT;
               cfg_reg.enable <= wdt_enable_in;
            end else begin
               cfg_reg.generator <= GEN_CLEARED;
               cfg_reg.enable <= 1'b0;
            end
         end
      end else if (strap_load_in && IS_WATCHDOG) begin
         // The straps are caught after release because an async reset may only load constants.
         cfg_reg.enable <= wdt_enable_in;
         cfg_reg.lock <= wdt_always_on_in;
      end else if (write_in && !cfg_reg.lock) begin
         cfg_reg <= write_cfg_in;
      end
   end

   assign cfg_out = cfg_reg;

endmodule : channel_slot

// [core/generic_clock_channel_control.sv]
// Overview of operation
// - Enable bit 14 delivers the channel clock when one, stops it when zero.
// - Generator field bits 11:8 picks generators 0 to 7; codes 8 to 15 reserved.
// - Selector bits 5:0 names the channel that a field write configures.
// - Power reset returns every channel, the real-time counter included, to defaults.
// - User reset touches a channel only if unlocked, and the real-time counter only if also disabled.
// - Real-time counter channel clears on user reset only when unlocked and disabled.
// - Power reset gives generator 0, off, unlocked; watchdog takes generator 2, strap enable, and strap lock unless user reset coincides with the load.
// - Unlocked watchdog takes generator 2 and strap enable on user reset; lock unchanged.
// - Other unlocked channels clear on user reset, the real-time counter only if also disabled; locked ones keep everything.
// - Selector codes 0x00 to 0x1B name channels; 0x1C upward are reserved.
// - A locked channel refuses writes until power reset; generator 0 never locks.
`timescale 1ns/100ps
module generic_clock_channel_control
   import clock_channel_pkg::*;
(
   // Clock and power reset
   input wire logic clock_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [DATA_W-1:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Asynchronous system inputs
   input wire logic user_reset_in,
   input wire logic wdt_enable_nvm_in,
   input wire logic wdt_always_on_nvm_in,
   // Channel configuration towards the peripherals
   output chan_cfg_t [NUM_CHANNELS-1:0] channel_cfg_out,
   output logic [NUM_GENERATORS-1:0] generator_locked_out,
   output logic config_ready_out
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   strap_t strap_raw;
   strap_t strap_stable;
   logic [1:0] settle_reg;
   logic settled_reg;
   logic ready_reg;
   logic strap_load;
   logic [SEL_W-1:0] selector_reg;
   logic [SEL_W-1:0] selector_next;
   logic pready_reg;
   logic pslverr_reg;
   logic [DATA_W-1:0] prdata_reg;
   logic [DATA_W-1:0] read_value;
   logic read_error;
   logic access_done;
   logic config_write;
   logic status_write;
   logic field_write;
   logic write_refused;
   logic refused_reg;
   chan_cfg_t write_cfg;
   chan_cfg_t selected_cfg;
   chan_cfg_t [NUM_CHANNELS-1:0] slot_cfg;
   logic [NUM_CHANNELS-1:0] slot_write;
   logic [NUM_GENERATORS-1:0] locked_gen;
   logic [NUM_GENERATORS-1:0] locked_gen_reg;

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   assign strap_raw.user_reset = user_reset_in;
   assign strap_raw.wdt_enable = wdt_enable_nvm_in;
   assign strap_raw.wdt_always_on = wdt_always_on_nvm_in;

   pin_sync #(
      .WIDTH(STRAP_W)
   ) strap_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .async_in(strap_raw),
      .stable_out(strap_stable)
   );

   // ----------------------------------------------------------------
   // Start-up: wait for settled straps, then load the watchdog channel
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         settle_reg <= 2'h0;
      end else if (settle_reg != SETTLE_COUNT) begin
         settle_reg <= settle_reg + 2'h1;
      end
   end

   // The synchroniser holds its settled copy one stage behind its third flop, so the load
   // waits one more edge; loading earlier would catch the reset value of the straps.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         settled_reg <= 1'b0;
      end else begin
         settled_reg <= (settle_reg == SETTLE_COUNT);
      end
   end

   assign strap_load = settled_reg && !ready_reg;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ready_reg <= 1'b0;
      end else if (strap_load) begin
         ready_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign access_done = psel_in && penable_in && pready_reg;
   assign config_write = access_done && pwrite_in && (paddr_in == CONFIG_ADDR);
   assign status_write = access_done && pwrite_in && (paddr_in == STATUS_ADDR);
   assign field_write = config_write && pstrb_in[FIELD_LANE];

   // A write carrying both lanes configures the channel named in the same word.
   always_comb begin
      selector_next = selector_reg;
      if (config_write && pstrb_in[SEL_LANE]) begin
         selector_next = pwdata_in[SEL_MSB:SEL_LSB];
      end
   end

   always_comb begin
      write_cfg.generator = pwdata_in[GEN_MSB:GEN_LSB];
      write_cfg.enable = pwdata_in[ENABLE_BIT];
      // Generator zero clocks the core, so a lock request naming it is dropped.
      write_cfg.lock = pwdata_in[LOCK_BIT] && (write_cfg.generator != GEN_CLEARED);
   end

   // ----------------------------------------------------------------
   // Write steering and refusal
   // ----------------------------------------------------------------
   always_comb begin
      write_refused = 1'b0;
      if (field_write) begin
         if (selector_next > CH_LAST) begin
            write_refused = 1'b1;
         end else if (write_cfg.generator > GEN_LAST) begin
            write_refused = 1'b1;
         end else if (slot_cfg[selector_next[4:0]].lock) begin
            write_refused = 1'b1;
         end else if (strap_stable.user_reset) begin
            write_refused = 1'b1;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         slot_write[i] = field_write && !write_refused
                         && (selector_next == SEL_W'(i));
      end
   end

   // ----------------------------------------------------------------
   // Selector register
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         selector_reg <= CH_FLL_REF;
      end else if (strap_stable.user_reset) begin
         selector_reg <= CH_FLL_REF;
      end else begin
         selector_reg <= selector_next;
      end
   end

   // ----------------------------------------------------------------
   // Channel storage
   // ----------------------------------------------------------------
   generate
      for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_slot
         channel_slot #(
            .IS_WATCHDOG(SEL_W'(ch) == CH_WATCHDOG),
            .IS_RTC(SEL_W'(ch) == CH_RTC)
         ) slot (
            .clock_in(clock_in),
            .rst_in(rst_in),
            .user_reset_in(strap_stable.user_reset),
            .strap_load_in(strap_load),
            .wdt_enable_in(strap_stable.wdt_enable),
            .wdt_always_on_in(strap_stable.wdt_always_on),
            .write_in(slot_write[ch]),
            .write_cfg_in(write_cfg),
            .cfg_out(slot_cfg[ch])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Locked generator summary
   // ----------------------------------------------------------------
   always_comb begin
      locked_gen = '0;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         if (slot_cfg[i].lock) begin
            locked_gen[slot_cfg[i].generator[2:0]] = 1'b1;
         end
      end
      locked_gen[0] = 1'b0;
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         locked_gen_reg <= '0;
      end else begin
         locked_gen_reg <= locked_gen;
      end
   end

   // ----------------------------------------------------------------
   // Refused-write flag
   // ----------------------------------------------------------------
   // A refusal in the clearing cycle stays visible, so software never misses one.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         refused_reg <= 1'b0;
      end else if (write_refused) begin
         refused_reg <= 1'b1;
      end else if (status_write && pstrb_in[0] && pwdata_in[STAT_REFUSED_BIT]) begin
         refused_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      selected_cfg = CFG_CLEARED;
      if (selector_reg <= CH_LAST) begin
         selected_cfg = slot_cfg[selector_reg[4:0]];
      end
   end

   always_comb begin
      read_value = '0;
      read_error = 1'b0;
      if (paddr_in == CONFIG_ADDR) begin
         read_value[SEL_MSB:SEL_LSB] = selector_reg;
         read_value[GEN_MSB:GEN_LSB] = selected_cfg.generator;
         read_value[ENABLE_BIT] = selected_cfg.enable;
         read_value[LOCK_BIT] = selected_cfg.lock;
      end else if (paddr_in == STATUS_ADDR) begin
         read_value[STAT_REFUSED_BIT] = refused_reg;
         read_value[STAT_READY_BIT] = ready_reg;
         read_value[STAT_LOCKGEN_MSB:STAT_LOCKGEN_LSB] = locked_gen_reg;
      end else begin
         read_error = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // Answers are held back until the straps are loaded, which stalls the master safely.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= psel_in && !pready_reg && ready_reg;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
      end else if (psel_in && !pready_reg && ready_reg) begin
         prdata_reg <= pwrite_in ? '0 : read_value;
         pslverr_reg <= read_error;
      end else if (access_done) begin
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata_out = prdata_reg;
   assign pready_out = pready_reg;
   assign pslverr_out = pslverr_reg;
   assign channel_cfg_out = slot_cfg;
   assign generator_locked_out = locked_gen_reg;
   assign config_ready_out = ready_reg;

endmodule : generic_clock_channel_control

// [sim/gclk_ctl_asserts.sv]
`timescale 1ns/100ps
module gclk_ctl_asserts
   import clock_channel_pkg::*;
(
   // Clock, resets and straps
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic user_reset_in,
   input wire logic wdt_enable_nvm_in,
   input wire logic wdt_always_on_nvm_in,
   // Observed outputs
   input wire chan_cfg_t [NUM_CHANNELS-1:0] channel_cfg_out,
   input wire logic [NUM_GENERATORS-1:0] generator_locked_out,
   input wire logic config_ready_out
);
   chan_cfg_t [NUM_CHANNELS-1:0] prev_reg;
   logic [NUM_GENERATORS-1:0] lk_gen;
   logic lock_moved;
   logic bad_gen;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= channel_cfg_out;
      end
   end
   // The locked set is rebuilt from the channels, so the flag vector is judged on its own.
   always_comb begin
      lk_gen = '0;
      lock_moved = 1'b0;
      bad_gen = 1'b0;
      for (int k = 0; k < NUM_CHANNELS; k++) begin
         bad_gen = bad_gen | (channel_cfg_out[k].generator > GEN_LAST);
         lock_moved = lock_moved | (prev_reg[k].lock && channel_cfg_out[k] != prev_reg[k]);
         if (channel_cfg_out[k].lock) begin
            lk_gen[channel_cfg_out[k].generator[2:0]] = 1'b1;
         end
      end
   end
   property p_gen_range; !bad_gen; endproperty
   a_gen_range: assert property (p_gen_range) else $error("reserved generator stored");
   property p_lock_hold; !lock_moved; endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked channel changed");
   property p_gen0; !generator_locked_out[0]; endproperty
   a_gen0: assert property (p_gen0) else $error("generator zero locked");
   property p_lk_map; generator_locked_out == $past(lk_gen); endproperty
   a_lk_map: assert property (p_lk_map) else $error("locked generator map wrong");
   property p_boot; $rose(config_ready_out) |-> channel_cfg_out[CH_RTC] == CFG_CLEARED
      && channel_cfg_out[CH_WATCHDOG] == {wdt_always_on_nvm_in, wdt_enable_nvm_in, 4'h2};
   endproperty
   a_boot: assert property (p_boot) else $error("power reset values wrong");
   property p_rtc_ur; user_reset_in [*8] |-> $stable(channel_cfg_out[CH_RTC])
      && (channel_cfg_out[CH_RTC][5:4] != 2'b00 || channel_cfg_out[CH_RTC] == CFG_CLEARED);
   endproperty
   a_rtc_ur: assert property (p_rtc_ur) else $error("rtc channel user reset wrong");
   property p_wdt_ur; user_reset_in [*8] |-> channel_cfg_out[CH_WATCHDOG].lock
      || channel_cfg_out[CH_WATCHDOG][4:0] == {wdt_enable_nvm_in, 4'h2}; endproperty
   a_wdt_ur: assert property (p_wdt_ur) else $error("watchdog user reset wrong");
   property p_oth_ur; user_reset_in [*8] |-> channel_cfg_out[CH_EVENT_FIRST].lock
      || channel_cfg_out[CH_EVENT_FIRST] == CFG_CLEARED; endproperty
   a_oth_ur: assert property (p_oth_ur) else $error("channel not cleared");
endmodule : gclk_ctl_asserts
bind generic_clock_channel_control gclk_ctl_asserts gclk_ctl_asserts_i (
   .clock_in(clock_in), .rst_in(rst_in), .user_reset_in(user_reset_in),
   .wdt_enable_nvm_in(wdt_enable_nvm_in), .wdt_always_on_nvm_in(wdt_always_on_nvm_in),
   .channel_cfg_out(channel_cfg_out), .generator_locked_out(generator_locked_out),
   .config_ready_out(config_ready_out));

// [sim/periph_sink.sv]
`timescale 1ns/100ps
module periph_sink
   import clock_channel_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Channel settings
   input wire chan_cfg_t [NUM_CHANNELS-1:0] cfg_in,
   // Delivered clocks
   output logic [NUM_CHANNELS-1:0] chan_clk_out
);
   logic [NUM_GENERATORS-1:0] gen_reg;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         gen_reg <= '0;
      end else begin
         gen_reg <= gen_reg + 8'h01;
      end
   end
   // A reserved code reaches no generator, so a leak shows up as a stopped clock.
   always_comb begin
      for (int k = 0; k < NUM_CHANNELS; k++) begin
         chan_clk_out[k] = cfg_in[k].enable && cfg_in[k].generator <= GEN_LAST
            && gen_reg[cfg_in[k].generator[2:0]];
      end
   end
endmodule : periph_sink

// [sim/generic_clock_channel_control_tb.sv]
`timescale 1ns/100ps
module generic_clock_channel_control_tb
   import clock_channel_pkg::*;
;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [3:0] pstrb = 4'h0;
   logic usr = 1'b0;
   logic wen = 1'b1;
   logic won = 1'b0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   chan_cfg_t [NUM_CHANNELS-1:0] cfg;
   logic [NUM_GENERATORS-1:0] lkgen;
   logic cready;
   logic [NUM_CHANNELS-1:0] chclk;
   logic [DATA_W-1:0] rd;
   logic err;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   generic_clock_channel_control generic_clock_channel_control_i (
      .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .user_reset_in(usr), .wdt_enable_nvm_in(wen), .wdt_always_on_nvm_in(won),
      .channel_cfg_out(cfg), .generator_locked_out(lkgen), .config_ready_out(cready));
   periph_sink periph_sink_i (.clock_in(clock_in), .rst_in(rst_in), .cfg_in(cfg),
      .chan_clk_out(chclk));
   always #5 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   // An idle cycle follows each transfer, so no signal is driven twice in one step.
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock_in);
      penable <= 1'b1;
      do begin
         @(posedge clock_in);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_in);
   endtask : apb
   function automatic logic [31:0] cw(input logic [5:0] s, input chan_cfg_t c);
      return {16'h0, c.lock, c.enable, 2'b00, c.generator, 2'b00, s};
   endfunction : cw
   task automatic wcfg(input logic [5:0] s, input chan_cfg_t c);
      apb(1'b1, CONFIG_ADDR, cw(s, c), 4'h3);
   endtask : wcfg
   task automatic stat(input logic exp);
      apb(1'b0, STATUS_ADDR, '0, 4'h0);
      check(rd[0], exp, "refused flag");
      apb(1'b1, STATUS_ADDR, 32'h1, 4'h1);
   endtask : stat
   task automatic user_pulse();
      usr <= 1'b1;
      repeat (10) @(posedge clock_in);
      usr <= 1'b0;
      repeat (10) @(posedge clock_in);
   endtask : user_pulse
   task automatic t_clk(input int ch, input logic on);
      int n;
      logic last;
      n = 0;
      last = chclk[ch];
      repeat (300) begin
         @(posedge clock_in);
         n = n + (chclk[ch] !== last);
         last = chclk[ch];
      end
      check(n > 0, on, "gating");
   endtask : t_clk
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_boot();
      int n;
      n = 0;
      while (cready !== 1'b1 && n < 20) begin
         @(posedge clock_in);
         n++;
      end
      check(cready, 1'b1, "ready");
      for (int k = 0; k < NUM_CHANNELS; k++) begin
         check(cfg[k], k == 1 ? {won, wen, 4'h2} : CFG_CLEARED, "boot");
      end
      apb(1'b0, 12'hFF0, '0, 4'h0);
      check(err, 1'b1, "unmapped");
   endtask : t_boot
   task automatic t_all();
      chan_cfg_t c;
      for (int k = 0; k < NUM_CHANNELS; k++) begin
         c = {1'b0, k[0], k[3:0] & 4'h7};
         wcfg(6'(k), c);
         check(cfg[k], c, "write");
      end
      for (int k = 0; k < NUM_CHANNELS; k++) begin
         c = {1'b0, k[0], k[3:0] & 4'h7};
         apb(1'b1, CONFIG_ADDR, 32'(k), 4'h1);
         apb(1'b0, CONFIG_ADDR, '0, 4'h0);
         check(rd, cw(6'(k), c), "readback");
      end
      t_clk(5, 1'b1);
      t_clk(4, 1'b0);
   endtask : t_all
   task automatic t_gen();
      chan_cfg_t e;
      e = 6'h13;
      for (int g = 0; g < 16; g++) begin
         e = g < 8 ? {2'b01, 4'(g)} : e;
         wcfg(CH_EXT_INT, {2'b01, 4'(g)});
         check(cfg[CH_EXT_INT], e, "generator");
         stat(g > 7);
      end
      wcfg(6'h1C, 6'h11);
      apb(1'b0, CONFIG_ADDR, '0, 4'h0);
      check(rd, cw(6'h1C, CFG_CLEARED), "reserved id");
      stat(1'b1);
   endtask : t_gen
   task automatic t_lock();
      wcfg(6'h0D, 6'h35);
      @(posedge clock_in);
      check(cfg[13], 6'h35, "lock");
      check(lkgen, 8'h20, "locked gens");
      wcfg(6'h0D, 6'h01);
      check(cfg[13], 6'h35, "locked write");
      stat(1'b1);
      wcfg(6'h0E, 6'h30);
      check(cfg[14], 6'h10, "gen zero lock");
      stat(1'b0);
   endtask : t_lock
   task automatic t_user();
      wcfg(CH_RTC, 6'h13);
      wcfg(CH_EVENT_FIRST, 6'h14);
      wcfg(CH_WATCHDOG, 6'h16);
      user_pulse();
      check(cfg[CH_RTC], 6'h13, "rtc kept");
      check(cfg[CH_EVENT_FIRST], CFG_CLEARED, "cleared");
      check(cfg[CH_WATCHDOG], {1'b0, wen, 4'h2}, "watchdog");
      check(cfg[13], 6'h35, "locked kept");
      wcfg(CH_RTC, 6'h03);
      user_pulse();
      check(cfg[CH_RTC], CFG_CLEARED, "rtc cleared");
   endtask : t_user
   // Straps change only under power reset, where they have time to settle.
   task automatic t_power();
      rst_in <= 1'b1;
      wen <= 1'b0;
      won <= 1'b1;
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      t_boot();
      user_pulse();
      check(cfg[CH_WATCHDOG], 6'h22, "watchdog locked");
      wcfg(CH_WATCHDOG, 6'h13);
      check(cfg[CH_WATCHDOG], 6'h22, "watchdog write");
      check(lkgen, 8'h04, "watchdog gen");
   endtask : t_power
   initial begin
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      t_boot();
      t_all();
      t_gen();
      t_lock();
      t_user();
      t_power();
      end_of_test();
   end
endmodule : generic_clock_channel_control_tb
